// [hw/arpc_walker.sv]
`timescale 1ns/1ps
// Behaviour
// - Permutation setting maps operand to load cycle
// - Group start empties all port reservations
// - Same GPR address shares, different one conflicts
// - Constant slots scanned one then zero
// - Constant match needs address and channel pair
// - Each GPR operand reserves its permuted cycle
// - Second operand equal to first reserves nothing
// - Only constant buffer operands reserve constant ports
// - Previous vector results bypass every check
// - Comparisons use address after relative index
// - Three read ports per element memory
module arpc_walker #(
   // Counters below are sized for four slots of three sources
   parameter int SLOTS = arpc_pkg::ARPC_SLOTS,
   parameter int SRCS = arpc_pkg::ARPC_SRCS
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Group handshake
   input wire logic group_valid,
   output logic group_ready,
   // Operand fields, indexed slot-major then source
   input wire arpc_pkg::arpc_kind_t src_kind [SLOTS][SRCS],
   input wire arpc_pkg::arpc_addr_t src_addr [SLOTS][SRCS],
   input wire logic [1:0] src_elem [SLOTS][SRCS],
   input wire logic src_rel [SLOTS][SRCS],
   input wire logic [1:0] src_count [SLOTS],
   input wire logic slot_valid [SLOTS],
   input wire arpc_pkg::arpc_perm_t perm [SLOTS],
   input wire logic [arpc_pkg::ARPC_REL_W-1:0] rel_index,
   // Result
   output logic result_valid,
   output logic illegal,
   output logic gpr_conflict,
   output logic cbuf_conflict
);
   import arpc_pkg::*;

   // Reservation grid and constant slots behind one request bundle
   arpc_req_if req ();

   arpc_gpr_table arpc_gpr_table_i (
      .clk_sys(clk_sys),
      .reset(reset),
      .req(req)
   );

   arpc_state_t state_q;
   logic [1:0] slot_q;
   logic [1:0] src_q;
   logic gerr_q, cerr_q;
   logic last;
   arpc_kind_t kind;
   arpc_addr_t eff_addr, eff0;
   logic shared;

   // Effective address includes relative index
   assign eff_addr = src_rel[slot_q][src_q] ?
      src_addr[slot_q][src_q] + ARPC_ADDR_W'(rel_index) :
      src_addr[slot_q][src_q];
   assign eff0 = src_rel[slot_q][0] ?
      src_addr[slot_q][0] + ARPC_ADDR_W'(rel_index) : src_addr[slot_q][0];
   assign kind = src_kind[slot_q][src_q];
   assign shared = src_q == ARPC_SRC_SHARED &&
      src_kind[slot_q][0] == ARPC_KIND_GPR && eff0 == eff_addr &&
      src_elem[slot_q][0] == src_elem[slot_q][src_q];

   function automatic logic [1:0] cycle_of(arpc_perm_t p, logic [1:0] s);
      logic [1:0] c;
      c = ARPC_CYC_0;
      case (p)
         ARPC_PERM_012: c = s;
         ARPC_PERM_021: c = (s == 2'h0) ? ARPC_CYC_0 :
            (s == 2'h1) ? ARPC_CYC_2 : ARPC_CYC_1;
         ARPC_PERM_120: c = (s == 2'h0) ? ARPC_CYC_1 :
            (s == 2'h1) ? ARPC_CYC_2 : ARPC_CYC_0;
         ARPC_PERM_102: c = (s == 2'h0) ? ARPC_CYC_1 :
            (s == 2'h1) ? ARPC_CYC_0 : ARPC_CYC_2;
         ARPC_PERM_201: c = (s == 2'h0) ? ARPC_CYC_2 :
            (s == 2'h1) ? ARPC_CYC_0 : ARPC_CYC_1;
         ARPC_PERM_210: c = (s == 2'h0) ? ARPC_CYC_2 :
            (s == 2'h1) ? ARPC_CYC_1 : ARPC_CYC_0;
         default: c = s;
      endcase
      return c;
   endfunction

   wire walking = state_q == ARPC_ST_WALK;
   wire in_range = slot_valid[slot_q] && src_q < src_count[slot_q];
   assign req.gpr_req = walking && in_range && kind == ARPC_KIND_GPR &&
      !shared;
   // Literal, inline and PV never reserve
   assign req.cbuf_req = walking && in_range &&
      kind == ARPC_KIND_CBUF;
   assign req.addr = eff_addr;
   assign req.elem = src_elem[slot_q][src_q];
   assign req.cycle = cycle_of(perm[slot_q], src_q);
   assign req.clear = state_q == ARPC_ST_IDLE && group_valid;
   assign last = slot_q == 2'(SLOTS-1) && src_q == 2'(SRCS-1);
   assign group_ready = state_q == ARPC_ST_IDLE;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q <= ARPC_ST_IDLE;
      end else begin
         case (state_q)
            ARPC_ST_IDLE: if (group_valid) state_q <= ARPC_ST_WALK;
            ARPC_ST_WALK: if (last) state_q <= ARPC_ST_DONE;
            default: state_q <= ARPC_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset || state_q == ARPC_ST_IDLE) begin
         slot_q <= '0;
         src_q <= '0;
      end else if (walking) begin
         if (src_q == 2'(SRCS-1)) begin
            src_q <= '0;
            slot_q <= slot_q + 2'h1;
         end else begin
            src_q <= src_q + 2'h1;
         end
      end
   end

   // Any conflict in any slot marks the group
   always_ff @(posedge clk_sys) begin
      if (reset || req.clear) begin
         gerr_q <= 1'b0;
         cerr_q <= 1'b0;
      end else if (walking) begin
         gerr_q <= gerr_q | req.gpr_conflict;
         cerr_q <= cerr_q | req.cbuf_exhausted;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         result_valid <= 1'b0;
         illegal <= 1'b0;
         gpr_conflict <= 1'b0;
         cbuf_conflict <= 1'b0;
      end else begin
         result_valid <= walking && last;
         if (walking && last) begin
            gpr_conflict <= gerr_q | req.gpr_conflict;
            cbuf_conflict <= cerr_q | req.cbuf_exhausted;
            illegal <= gerr_q | req.gpr_conflict | cerr_q |
               req.cbuf_exhausted;
         end
      end
   end
endmodule

// [hw/arpc_pkg.sv]
package arpc_pkg;
   localparam int ARPC_SLOTS = 4;
   localparam int ARPC_SRCS = 3;
   localparam int ARPC_CYCLES = 3;
   localparam int ARPC_ELEMS = 4;
   localparam int ARPC_CRES = 4;
   // Only slots 1 and 0 are ever scanned, so only two are kept
   localparam int ARPC_CSCAN = 2;
   localparam int ARPC_ADDR_W = 9;
   localparam int ARPC_REL_W = 9;

   typedef enum logic [2:0] {
      ARPC_PERM_012 = 3'h0,
      ARPC_PERM_021 = 3'h1,
      ARPC_PERM_120 = 3'h2,
      ARPC_PERM_102 = 3'h3,
      ARPC_PERM_201 = 3'h4,
      ARPC_PERM_210 = 3'h5
   } arpc_perm_t;

   // Operand source kinds
   typedef enum logic [2:0] {
      ARPC_KIND_NONE = 3'h0,
      ARPC_KIND_GPR = 3'h1,
      ARPC_KIND_CBUF = 3'h2,
      ARPC_KIND_LIT = 3'h3,
      ARPC_KIND_INLINE = 3'h4,
      ARPC_KIND_PV = 3'h5
   } arpc_kind_t;

   typedef enum logic [1:0] {
      ARPC_ST_IDLE = 2'h0,
      ARPC_ST_WALK = 2'h1,
      ARPC_ST_DONE = 2'h2
   } arpc_state_t;

   typedef logic [ARPC_ADDR_W-1:0] arpc_addr_t;

   localparam logic [1:0] ARPC_CYC_0 = 2'h0;
   localparam logic [1:0] ARPC_CYC_1 = 2'h1;
   localparam logic [1:0] ARPC_CYC_2 = 2'h2;
   localparam logic [1:0] ARPC_ELEM_X = 2'h0;
   localparam logic [1:0] ARPC_ELEM_Z = 2'h2;
   localparam logic ARPC_CRES_SLOT_HI = 1'b1;
   localparam logic ARPC_CRES_SLOT_LO = 1'b0;
   localparam logic [1:0] ARPC_SRC_SHARED = 2'h1;
endpackage

// [hw/arpc_req_if.sv]
`timescale 1ns/1ps
interface arpc_req_if;
   import arpc_pkg::*;
   logic gpr_req;
   logic cbuf_req;
   arpc_addr_t addr;
   logic [1:0] elem;
   logic [1:0] cycle;
   logic gpr_conflict;
   logic cbuf_exhausted;
   logic clear;

   modport walker (output gpr_req, cbuf_req, addr, elem, cycle, clear,
      input gpr_conflict, cbuf_exhausted);
   modport table_side (input gpr_req, cbuf_req, addr, elem, cycle, clear,
      output gpr_conflict, cbuf_exhausted);
endinterface

// [hw/arpc_gpr_table.sv]
`timescale 1ns/1ps
module arpc_gpr_table (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Reservation requests
   arpc_req_if.table_side req
);
   import arpc_pkg::*;
   logic [ARPC_CYCLES*ARPC_ELEMS-1:0] used_q;
   arpc_addr_t addr_q [ARPC_CYCLES*ARPC_ELEMS];
   logic [ARPC_CSCAN-1:0] cused_q;
   arpc_addr_t caddr_q [ARPC_CSCAN];
   logic cpair_q [ARPC_CSCAN];
   logic [3:0] gidx;
   logic cpair;
   logic hi_match, lo_match, hi_empty, lo_empty;

   assign gidx = 4'(req.cycle) * 4'(ARPC_ELEMS) + 4'(req.elem);
   assign cpair = req.elem[1];

   // GPR grid, one port per cycle and element memory
   always_ff @(posedge clk_sys) begin
      if (reset || req.clear) begin
         used_q <= '0;
      end else if (req.gpr_req && !used_q[gidx]) begin
         used_q[gidx] <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (req.gpr_req && !used_q[gidx]) begin
         addr_q[gidx] <= req.addr;
      end
   end

   assign req.gpr_conflict = req.gpr_req && used_q[gidx] &&
      (addr_q[gidx] != req.addr);

   // Constant slots scanned 1 then 0; match beats empty
   // Each slot holds one address and pair, so two pairs at most
   always_comb begin
      hi_empty = !cused_q[ARPC_CRES_SLOT_HI];
      lo_empty = !cused_q[ARPC_CRES_SLOT_LO];
      hi_match = !hi_empty && caddr_q[ARPC_CRES_SLOT_HI] == req.addr &&
         cpair_q[ARPC_CRES_SLOT_HI] == cpair;
      lo_match = !lo_empty && caddr_q[ARPC_CRES_SLOT_LO] == req.addr &&
         cpair_q[ARPC_CRES_SLOT_LO] == cpair;
   end

   assign req.cbuf_exhausted = req.cbuf_req && !hi_match && !lo_match &&
      !hi_empty && !lo_empty;

   always_ff @(posedge clk_sys) begin
      if (reset || req.clear) begin
         cused_q <= '0;
      end else if (req.cbuf_req && !hi_match && !lo_match) begin
         // Last empty slot in scan order 1,0 is slot 0
         if (lo_empty) begin
            cused_q[ARPC_CRES_SLOT_LO] <= 1'b1;
         end else if (hi_empty) begin
            cused_q[ARPC_CRES_SLOT_HI] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (req.cbuf_req && !hi_match && !lo_match) begin
         if (lo_empty) begin
            caddr_q[ARPC_CRES_SLOT_LO] <= req.addr;
            cpair_q[ARPC_CRES_SLOT_LO] <= cpair;
         end else if (hi_empty) begin
            caddr_q[ARPC_CRES_SLOT_HI] <= req.addr;
            cpair_q[ARPC_CRES_SLOT_HI] <= cpair;
         end
      end
   end
endmodule

// [dv/arpc_issue_model.sv]
`timescale 1ns/1ps
module arpc_issue_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Handshake
   input wire logic go,
   input wire logic group_ready,
   output logic group_valid
);
   // Request stays up until taken, as issue logic must hold it
   always_ff @(posedge clk_sys) begin
      if (reset || (group_valid && group_ready)) group_valid <= 1'b0;
      else if (go) group_valid <= 1'b1;
   end
endmodule

// [dv/arpc_walker_props.sv]
`timescale 1ns/1ps
module arpc_walker_props (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Handshake and verdict
   input wire logic group_valid,
   input wire logic group_ready,
   input wire logic result_valid,
   input wire logic illegal,
   input wire logic gpr_conflict,
   input wire logic cbuf_conflict
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   wire logic take = group_valid && group_ready;
   answer_time_a: assert property (take |-> ##13 result_valid)
      else $error("no result 13 cycles after take");
   result_cause_a: assert property (
      result_valid |-> $past(take, 13))
      else $error("result without take");
   result_pulse_a: assert property (result_valid |=> !result_valid)
      else $error("result longer than one cycle");
   verdict_join_a: assert property (
      result_valid |-> illegal == (gpr_conflict || cbuf_conflict))
      else $error("illegal not the sum of conflicts");
   flags_hold_a: assert property (
      !result_valid |-> $stable({illegal, gpr_conflict, cbuf_conflict}))
      else $error("flags moved between results");
   busy_refuse_a: assert property (take |=> !group_ready [*8])
      else $error("ready while walking");
   ready_again_a: assert property (result_valid |=> group_ready)
      else $error("not ready after result");
   reset_idle_a: assert property (
      $fell(reset) |-> group_ready && !illegal && !result_valid)
      else $error("not idle after reset");
   cover property (take);
   cover property (result_valid && illegal);
   cover property (result_valid && !illegal);
   cover property (result_valid && cbuf_conflict);
endmodule
bind arpc_walker arpc_walker_props arpc_walker_props_i (.clk_sys, .reset,
   .group_valid, .group_ready, .result_valid, .illegal, .gpr_conflict,
   .cbuf_conflict);

// [dv/test_alu_read_port_checker.sv]
`timescale 1ns/1ps
`define CHK(n, g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module test_alu_read_port_checker;
   import arpc_pkg::*;
   localparam int CY [6][3] = '{'{0, 1, 2}, '{0, 2, 1}, '{1, 2, 0},
      '{1, 0, 2}, '{2, 0, 1}, '{2, 1, 0}};
   logic clk_sys = 0, reset = 1, go = 0;
   logic group_valid, group_ready, result_valid;
   logic illegal, gpr_conflict, cbuf_conflict;
   arpc_kind_t src_kind [ARPC_SLOTS][ARPC_SRCS];
   arpc_addr_t src_addr [ARPC_SLOTS][ARPC_SRCS];
   logic [1:0] src_elem [ARPC_SLOTS][ARPC_SRCS];
   logic src_rel [ARPC_SLOTS][ARPC_SRCS];
   logic [1:0] src_count [ARPC_SLOTS];
   logic slot_valid [ARPC_SLOTS];
   arpc_perm_t perm [ARPC_SLOTS];
   logic [ARPC_REL_W-1:0] rel_index;
   int n_mismatch = 0, checks = 0, cyc_n = 0;
   arpc_walker arpc_walker_i (.*);
   arpc_issue_model arpc_issue_model_i (.*);
   always #50 clk_sys = ~clk_sys;
   // Bit 1 GPR conflict, bit 0 constant ports exhausted
   function automatic logic [1:0] expect_res();
      arpc_addr_t g [3][4], c [2], a, a0;
      bit gu [3][4] = '{default: 0};
      bit cu [2] = '{default: 0};
      bit cp [2];
      logic [1:0] r = 2'h0, e;
      int y, k;
      for (int i = 0; i < 4; i++) for (int s = 0; s < 3; s++)
         if (slot_valid[i] && s < src_count[i]) begin
            a = src_addr[i][s] + (src_rel[i][s] ? rel_index : 0);
            if (s == 0) a0 = a;
            e = src_elem[i][s];
            y = CY[perm[i]][s];
            if (src_kind[i][s] == ARPC_KIND_GPR) begin
               if (s == 1 && src_kind[i][0] == ARPC_KIND_GPR && a == a0 &&
                  e == src_elem[i][0]) r = r;
               else if (!gu[y][e]) begin
                  gu[y][e] = 1;
                  g[y][e] = a;
               end else if (g[y][e] != a) r[1] = 1;
            end else if (src_kind[i][s] == ARPC_KIND_CBUF) begin
               if ((cu[1] && c[1] == a && cp[1] == e[1]) ||
                  (cu[0] && c[0] == a && cp[0] == e[1])) r = r;
               else if (!cu[0] || !cu[1]) begin
                  // Scan 1 then 0 leaves slot 0 as the last empty one
                  k = cu[0];
                  cu[k] = 1;
                  c[k] = a;
                  cp[k] = e[1];
               end else r[0] = 1;
            end
         end
      return r;
   endfunction
   // Narrow address range so conflicts and sharing happen often
   task automatic fill(input bit rnd, input bit d);
      for (int i = 0; i < 4; i++) begin
         for (int s = 0; s < 3; s++) begin
            src_kind[i][s] <= rnd ? arpc_kind_t'($urandom_range(5)) :
               (s == 0 && !d) ? ARPC_KIND_CBUF : ARPC_KIND_GPR;
            src_addr[i][s] <= rnd ? $urandom_range(3) : d ? i :
               (s == 0) ? i / 2 : 5;
            // Directed constants: C0.X, C0.Y, C1.Z, C1.W, two pairs
            src_elem[i][s] <= rnd ? $urandom_range(3) :
               (s == 0 && !d) ? i : 0;
            src_rel[i][s] <= rnd ? $urandom_range(1) : 0;
         end
         src_count[i] <= rnd ? $urandom_range(3) : 2;
         slot_valid[i] <= rnd ? $urandom_range(1) : (!d || i < 3);
         perm[i] <= arpc_perm_t'(rnd ? $urandom_range(5) :
            d ? (i ? i + 2 : 0) : i);
      end
      rel_index <= $urandom_range(3);
   endtask
   task automatic run_grp(input bit rnd, input bit d, input int t);
      logic [1:0] e;
      int n = 0;
      @(posedge clk_sys);
      fill(rnd, d);
      @(posedge clk_sys);
      e = expect_res();
      go <= 1;
      @(posedge clk_sys);
      go <= 0;
      while (result_valid !== 1'b1 && n < 40) begin
         @(posedge clk_sys) #1;
         n++;
      end
      if (n >= 40) n_mismatch++;
      `CHK("gpr", gpr_conflict, e[1])
      `CHK("cbuf", cbuf_conflict, e[0])
      `CHK("illegal", illegal, |e)
      $display("test %0d done", t);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc_n++;
      if (cyc_n == 10000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      void'($urandom(32'h6C0545D0));
      fill(1, 0);
      repeat (20) @(posedge clk_sys);
      reset <= 0;
      run_grp(0, 0, 0);
      run_grp(0, 1, 1);
      for (int t = 2; t < 300; t++) run_grp(1, 0, t);
      give_verdict();
   end
endmodule
